// File: hw/pwm_mode_pkg.sv
// Constants and carrier types for the PWM buffer mode select block
`default_nettype none

package pwm_mode_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int REG_W  = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE       = 8'h00;
  localparam logic [7:0] OFS_LEN        = 8'h08;
  localparam logic [7:0] OFS_LEN_SH     = 8'h14;
  localparam logic [7:0] OFS_DT_RISE    = 8'h68;
  localparam logic [7:0] OFS_DT_FALL    = 8'h6C;
  localparam logic [7:0] OFS_DT_RISE_SH = 8'h70;
  localparam logic [7:0] OFS_DT_FALL_SH = 8'h74;
  localparam logic [7:0] OFS_ADC_A      = 8'h7C;
  localparam logic [7:0] OFS_ADC_A_SH   = 8'h80;
  localparam logic [7:0] OFS_ADC_B      = 8'h84;
  localparam logic [7:0] OFS_ADC_B_SH   = 8'h88;

  // ----------------------------------------------------------------
  // Mode select field positions and reset values
  // ----------------------------------------------------------------
  localparam int ADCB_LSB  = 23;
  localparam int ADCA_LSB  = 21;
  localparam int LEN_LSB   = 19;
  localparam int DT_BIT    = 18;
  localparam int THR_BIT   = 16;
  localparam int PRE_BIT   = 4;
  localparam int SHAPE_LSB = 1;
  // Writable bits: 28..16, 8, 4..1; all others read zero
  localparam logic [31:0] MODE_WMASK = 32'h1FFF011E;
  localparam logic [31:0] MODE_RESET = 32'h00000000;
  localparam logic [31:0] WORK_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SHAPE_SAW  = 3'h1;
  localparam logic [2:0] SHAPE_TRI3 = 3'h6;
  localparam logic [2:0] SHAPE_TRI4 = 3'h7;
  localparam logic [1:0] XFER_NONE  = 2'h0;
  localparam logic [1:0] XFER_UP    = 2'h1;
  localparam logic [1:0] XFER_DOWN  = 2'h2;
  localparam logic [1:0] XFER_BOTH  = 2'h3;
  localparam logic [1:0] LEN_DIRECT = 2'h0;
  localparam logic [1:0] LEN_SINGLE = 2'h1;

  typedef enum logic [1:0] {
    SHAPE_OTHER,
    SHAPE_SAWTOOTH,
    SHAPE_TRI_DOWN,
    SHAPE_TRI_BOTH
  } count_shape_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic period;
    logic up_end;
    logic down_end;
  } counter_evt_t;

  typedef struct packed {
    logic adc_a;
    logic adc_b;
    logic deadtime;
    logic threshold;
  } buf_en_t;

  typedef struct packed {
    logic [1:0] adc_b_sel;
    logic [1:0] adc_a_sel;
    logic [1:0] len_sel;
    logic       dt_sel;
    logic       thr_sel;
    logic       pre_op;
    logic [2:0] shape;
  } mode_fields_t;

  typedef struct packed {
    logic len;
    logic dt;
    logic adc_a;
    logic adc_b;
  } xfer_t;

endpackage : pwm_mode_pkg

`default_nettype wire

// File: hw/shadow_reg.sv
// Working register with a shadow copy and a transfer strobe
`default_nettype none

module shadow_reg #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         work_wr,
  input  wire logic         shadow_wr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         buffered,
  input  wire logic         xfer,
  output logic      [W-1:0] work_q,
  output logic      [W-1:0] shadow_q
);

  if (W < 1 || W > 32) begin : g_w_check
    $error("shadow_reg: W must lie in 1..32");
  end

  // ----------------------------------------------------------------
  // Shadow copy
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shadow_q <= W'(pwm_mode_pkg::WORK_RESET);
    end else if (shadow_wr) begin
      shadow_q <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Working copy
  // ----------------------------------------------------------------
  // A direct software write wins over a transfer in the same cycle,
  // so the latest value software asked for is never overwritten.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      work_q <= W'(pwm_mode_pkg::WORK_RESET);
    end else if (work_wr) begin
      work_q <= wdata;
    end else if (buffered && xfer) begin
      work_q <= shadow_q;
    end
  end

endmodule // shadow_reg

`default_nettype wire

// File: hw/pwm_buffer_mode_select.sv
// Mode select register and buffer transfer control of one PWM channel
`default_nettype none

// Functional notes
// - Mode select register at offset 0x0, all bits zero after reset.
// - Bits 22..21 pick when ADC timing A shadow moves to working.
// - Sawtooth: 0 never, 1 at period expiry; 2 and 3 forbidden.
// - Triangle 3/4: 0 none, 1 up end, 2 down end, 3 both.
// - ADC timing A moves only if its field and enable bit allow.
// - Bits 24..23 do the same for ADC timing B, own enable.
// - Bits 20..19: 0 direct cycle length, 1 single buffer.
// - Buffered length moves at period end, or down end in triangle.
// - Bit 18 buffers both dead-time registers: 0 direct, 1 single.
// - Dead-time moves only if bit 18 and dead-time/threshold enables allow.
module pwm_buffer_mode_select #(
  parameter int DATA_W = 16
) (
  input  wire logic                              sys_clk,
  input  wire logic                              sys_rst,
  input  wire logic [pwm_mode_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [pwm_mode_pkg::REG_W-1:0]    reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [pwm_mode_pkg::REG_W-1:0]    reg_rdata,
  input  wire logic                              timer_running,
  input  wire pwm_mode_pkg::counter_evt_t        counter_evt,
  input  wire pwm_mode_pkg::buf_en_t             common_buffer_enable,
  output pwm_mode_pkg::mode_fields_t             mode_fields,
  output logic      [DATA_W-1:0]                 cycle_length,
  output logic      [DATA_W-1:0]                 deadtime_rise,
  output logic      [DATA_W-1:0]                 deadtime_fall,
  output logic      [DATA_W-1:0]                 adc_start_timing_a,
  output logic      [DATA_W-1:0]                 adc_start_timing_b,
  output pwm_mode_pkg::xfer_t                    xfer_done
);

  // Checked when elaborated
  if (DATA_W < 1 || DATA_W > 32) begin : g_width_check
    $error("pwm_buffer_mode_select: DATA_W must lie in 1..32");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0]                 pwm_mode_select_q;
  logic [DATA_W-1:0]           wdata;
  logic [DATA_W-1:0]           len_sh;
  logic [DATA_W-1:0]           dt_rise_sh;
  logic [DATA_W-1:0]           dt_fall_sh;
  logic [DATA_W-1:0]           adc_a_sh;
  logic [DATA_W-1:0]           adc_b_sh;
  logic [1:0]                  adc_timing_a_xfer_sel;
  logic [1:0]                  adc_timing_b_xfer_sel;
  logic [1:0]                  cycle_len_buffer_sel;
  logic                        deadtime_buffer_sel;
  logic [2:0]                  counter_shape_sel;
  pwm_mode_pkg::count_shape_t  shape;
  logic                        ev_period;
  logic                        ev_up;
  logic                        ev_down;
  logic                        len_buffered;
  logic                        adc_a_buffered;
  logic                        adc_b_buffered;
  logic                        len_xfer;
  logic                        dt_xfer;
  logic                        adc_a_xfer;
  logic                        adc_b_xfer;
  pwm_mode_pkg::xfer_t         xfer_done_q;
  logic [31:0]                 rdata_q;

  assign wdata = reg_wdata[DATA_W-1:0];

  // ----------------------------------------------------------------
  // Mode select register
  // ----------------------------------------------------------------
  // Undefined bits never store, so they read zero; reserved bits are
  // stored as written, software is expected to leave them at zero.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwm_mode_select_q <= pwm_mode_pkg::MODE_RESET;
    end else if (reg_wr && reg_addr == pwm_mode_pkg::OFS_MODE) begin
      pwm_mode_select_q <= reg_wdata & pwm_mode_pkg::MODE_WMASK;
    end
  end

  assign adc_timing_b_xfer_sel = pwm_mode_select_q[pwm_mode_pkg::ADCB_LSB +: 2];
  assign adc_timing_a_xfer_sel = pwm_mode_select_q[pwm_mode_pkg::ADCA_LSB +: 2];
  assign cycle_len_buffer_sel  = pwm_mode_select_q[pwm_mode_pkg::LEN_LSB +: 2];
  assign deadtime_buffer_sel   = pwm_mode_select_q[pwm_mode_pkg::DT_BIT];
  assign counter_shape_sel     = pwm_mode_select_q[pwm_mode_pkg::SHAPE_LSB +: 3];

  assign mode_fields.adc_b_sel = adc_timing_b_xfer_sel;
  assign mode_fields.adc_a_sel = adc_timing_a_xfer_sel;
  assign mode_fields.len_sel   = cycle_len_buffer_sel;
  assign mode_fields.dt_sel    = deadtime_buffer_sel;
  assign mode_fields.thr_sel   = pwm_mode_select_q[pwm_mode_pkg::THR_BIT];
  assign mode_fields.pre_op    = pwm_mode_select_q[pwm_mode_pkg::PRE_BIT];
  assign mode_fields.shape     = counter_shape_sel;

  // ----------------------------------------------------------------
  // Counter shape and events
  // ----------------------------------------------------------------
  // A prohibited shape code disables every transfer rather than
  // guessing which counting direction was meant.
  always_comb begin
    unique case (counter_shape_sel)
      pwm_mode_pkg::SHAPE_SAW: begin
        shape = pwm_mode_pkg::SHAPE_SAWTOOTH;
      end
      pwm_mode_pkg::SHAPE_TRI3: begin
        shape = pwm_mode_pkg::SHAPE_TRI_DOWN;
      end
      pwm_mode_pkg::SHAPE_TRI4: begin
        shape = pwm_mode_pkg::SHAPE_TRI_BOTH;
      end
      default: begin
        shape = pwm_mode_pkg::SHAPE_OTHER;
      end
    endcase
  end

  // Transfers happen only while the timer runs
  assign ev_period = timer_running && counter_evt.period
                     && shape == pwm_mode_pkg::SHAPE_SAWTOOTH;
  assign ev_up     = timer_running && counter_evt.up_end
                     && (shape == pwm_mode_pkg::SHAPE_TRI_DOWN
                         || shape == pwm_mode_pkg::SHAPE_TRI_BOTH);
  assign ev_down   = timer_running && counter_evt.down_end
                     && (shape == pwm_mode_pkg::SHAPE_TRI_DOWN
                         || shape == pwm_mode_pkg::SHAPE_TRI_BOTH);

  // Moment selected by an ADC timing transfer field
  // Sawtooth has no up or down events,
  // so codes 2 and 3 never fire there.
  function automatic logic adc_moment(
    input logic [1:0] sel,
    input logic       period,
    input logic       up,
    input logic       down
  );
    logic hit;
    hit = 1'b0;
    unique case (sel)
      pwm_mode_pkg::XFER_NONE: begin
        hit = 1'b0;
      end
      pwm_mode_pkg::XFER_UP: begin
        hit = period || up;
      end
      pwm_mode_pkg::XFER_DOWN: begin
        hit = down;
      end
      pwm_mode_pkg::XFER_BOTH: begin
        hit = up || down;
      end
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Transfer decisions
  // ----------------------------------------------------------------
  assign len_buffered   = cycle_len_buffer_sel == pwm_mode_pkg::LEN_SINGLE;
  assign adc_a_buffered = adc_timing_a_xfer_sel != pwm_mode_pkg::XFER_NONE;
  assign adc_b_buffered = adc_timing_b_xfer_sel != pwm_mode_pkg::XFER_NONE;

  // Length codes 2 and 3 are prohibited:
  // they leave the length unbuffered and
  // software writes go straight through.
  assign len_xfer = len_buffered && (ev_period || ev_down);

  // Dead-time follows the counter's own transfer points: down end
  // for triangle mode 3, both ends for triangle mode 4.
  assign dt_xfer = deadtime_buffer_sel
                   && common_buffer_enable.deadtime
                   && common_buffer_enable.threshold
                   && (ev_period || ev_down
                       || (ev_up && shape == pwm_mode_pkg::SHAPE_TRI_BOTH));

  assign adc_a_xfer = common_buffer_enable.adc_a
                      && adc_moment(adc_timing_a_xfer_sel,
                                    ev_period, ev_up, ev_down);
  assign adc_b_xfer = common_buffer_enable.adc_b
                      && adc_moment(adc_timing_b_xfer_sel,
                                    ev_period, ev_up, ev_down);

  // ----------------------------------------------------------------
  // Working and shadow registers
  // ----------------------------------------------------------------
  shadow_reg #(
    .W (DATA_W)
  ) u_len (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .work_wr   (reg_wr && reg_addr == pwm_mode_pkg::OFS_LEN),
    .shadow_wr (reg_wr && reg_addr == pwm_mode_pkg::OFS_LEN_SH),
    .wdata     (wdata),
    .buffered  (len_buffered),
    .xfer      (len_xfer),
    .work_q    (cycle_length),
    .shadow_q  (len_sh)
  );

  shadow_reg #(
    .W (DATA_W)
  ) u_dt_rise (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .work_wr   (reg_wr && reg_addr == pwm_mode_pkg::OFS_DT_RISE),
    .shadow_wr (reg_wr && reg_addr == pwm_mode_pkg::OFS_DT_RISE_SH),
    .wdata     (wdata),
    .buffered  (deadtime_buffer_sel),
    .xfer      (dt_xfer),
    .work_q    (deadtime_rise),
    .shadow_q  (dt_rise_sh)
  );

  shadow_reg #(
    .W (DATA_W)
  ) u_dt_fall (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .work_wr   (reg_wr && reg_addr == pwm_mode_pkg::OFS_DT_FALL),
    .shadow_wr (reg_wr && reg_addr == pwm_mode_pkg::OFS_DT_FALL_SH),
    .wdata     (wdata),
    .buffered  (deadtime_buffer_sel),
    .xfer      (dt_xfer),
    .work_q    (deadtime_fall),
    .shadow_q  (dt_fall_sh)
  );

  shadow_reg #(
    .W (DATA_W)
  ) u_adc_a (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .work_wr   (reg_wr && reg_addr == pwm_mode_pkg::OFS_ADC_A),
    .shadow_wr (reg_wr && reg_addr == pwm_mode_pkg::OFS_ADC_A_SH),
    .wdata     (wdata),
    .buffered  (adc_a_buffered),
    .xfer      (adc_a_xfer),
    .work_q    (adc_start_timing_a),
    .shadow_q  (adc_a_sh)
  );

  shadow_reg #(
    .W (DATA_W)
  ) u_adc_b (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .work_wr   (reg_wr && reg_addr == pwm_mode_pkg::OFS_ADC_B),
    .shadow_wr (reg_wr && reg_addr == pwm_mode_pkg::OFS_ADC_B_SH),
    .wdata     (wdata),
    .buffered  (adc_b_buffered),
    .xfer      (adc_b_xfer),
    .work_q    (adc_start_timing_b),
    .shadow_q  (adc_b_sh)
  );

  // ----------------------------------------------------------------
  // Transfer report
  // ----------------------------------------------------------------
  // Pulses in the cycle the working register shows the moved value;
  // a transfer lost to a same-cycle software write is not reported.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      xfer_done_q <= '0;
    end else begin
      xfer_done_q.len   <= len_xfer
                           && !(reg_wr && reg_addr == pwm_mode_pkg::OFS_LEN);
      xfer_done_q.dt    <= dt_xfer
                           && !(reg_wr && reg_addr == pwm_mode_pkg::OFS_DT_RISE)
                           && !(reg_wr && reg_addr == pwm_mode_pkg::OFS_DT_FALL);
      xfer_done_q.adc_a <= adc_a_xfer
                           && !(reg_wr && reg_addr == pwm_mode_pkg::OFS_ADC_A);
      xfer_done_q.adc_b <= adc_b_xfer
                           && !(reg_wr && reg_addr == pwm_mode_pkg::OFS_ADC_B);
    end
  end

  assign xfer_done = xfer_done_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Data stand only in the cycle after the read strobe; unmapped
  // offsets and idle cycles read zero.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        pwm_mode_pkg::OFS_MODE: begin
          rdata_q <= pwm_mode_select_q;
        end
        pwm_mode_pkg::OFS_LEN: begin
          rdata_q <= 32'(cycle_length);
        end
        pwm_mode_pkg::OFS_LEN_SH: begin
          rdata_q <= 32'(len_sh);
        end
        pwm_mode_pkg::OFS_DT_RISE: begin
          rdata_q <= 32'(deadtime_rise);
        end
        pwm_mode_pkg::OFS_DT_FALL: begin
          rdata_q <= 32'(deadtime_fall);
        end
        pwm_mode_pkg::OFS_DT_RISE_SH: begin
          rdata_q <= 32'(dt_rise_sh);
        end
        pwm_mode_pkg::OFS_DT_FALL_SH: begin
          rdata_q <= 32'(dt_fall_sh);
        end
        pwm_mode_pkg::OFS_ADC_A: begin
          rdata_q <= 32'(adc_start_timing_a);
        end
        pwm_mode_pkg::OFS_ADC_A_SH: begin
          rdata_q <= 32'(adc_a_sh);
        end
        pwm_mode_pkg::OFS_ADC_B: begin
          rdata_q <= 32'(adc_start_timing_b);
        end
        pwm_mode_pkg::OFS_ADC_B_SH: begin
          rdata_q <= 32'(adc_b_sh);
        end
        default: begin
          rdata_q <= 32'h00000000;
        end
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // pwm_buffer_mode_select

`default_nettype wire

// File: tb/pwm_buffer_mode_select_assertions.sv
// Concurrent checks on the ports of the PWM buffer mode select block
`default_nettype none

module pwm_buffer_mode_select_assertions #(
  parameter int DATA_W = 16
) (
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire logic [7:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  input wire logic                       timer_running,
  input wire pwm_mode_pkg::counter_evt_t counter_evt,
  input wire pwm_mode_pkg::buf_en_t      common_buffer_enable,
  input wire pwm_mode_pkg::mode_fields_t mode_fields,
  input wire logic [DATA_W-1:0]          cycle_length,
  input wire logic [DATA_W-1:0]          deadtime_rise,
  input wire logic [DATA_W-1:0]          deadtime_fall,
  input wire logic [DATA_W-1:0]          adc_start_timing_a,
  input wire logic [DATA_W-1:0]          adc_start_timing_b,
  input wire pwm_mode_pkg::xfer_t        xfer_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Expected transfer conditions
  // ----------------------------------------------------------------
  logic        saw_m, tri_m, p, u, d, len_go, dt_go, a_go, b_go;
  logic [11:0] wfld;
  assign saw_m = mode_fields.shape == pwm_mode_pkg::SHAPE_SAW;
  assign tri_m = mode_fields.shape == pwm_mode_pkg::SHAPE_TRI3 ||
                 mode_fields.shape == pwm_mode_pkg::SHAPE_TRI4;
  assign p = timer_running && counter_evt.period;
  assign u = timer_running && counter_evt.up_end;
  assign d = timer_running && counter_evt.down_end;
  assign wfld = {reg_wdata[24:18], reg_wdata[16], reg_wdata[4:1]};
  assign len_go = mode_fields.len_sel == 2'h1 && (saw_m ? p : tri_m && d);
  assign dt_go = mode_fields.dt_sel && common_buffer_enable.deadtime &&
                 common_buffer_enable.threshold && (saw_m ? p : tri_m &&
                 (d || u && mode_fields.shape == pwm_mode_pkg::SHAPE_TRI4));
  assign a_go = common_buffer_enable.adc_a && (saw_m ? mode_fields.adc_a_sel == 2'h1 && p :
                tri_m && (mode_fields.adc_a_sel[0] && u || mode_fields.adc_a_sel[1] && d));
  assign b_go = common_buffer_enable.adc_b && (saw_m ? mode_fields.adc_b_sel == 2'h1 && p :
                tri_m && (mode_fields.adc_b_sel[0] && u || mode_fields.adc_b_sel[1] && d));

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside read answer");
  mode_rd_a: assert property (reg_rd && reg_addr == 8'h00 |=> (reg_rdata & 32'hE000FEE1) ==
    32'h00000000 && {reg_rdata[24:18], reg_rdata[16], reg_rdata[4:1]} == mode_fields)
    else $error("mode read data wrong");
  mode_wr_a: assert property (reg_wr && reg_addr == 8'h00 |=> mode_fields == $past(wfld))
    else $error("mode fields not taken from write");
  len_cause_a: assert property (xfer_done.len |-> $past(len_go))
    else $error("cycle length moved without cause");
  len_fire_a: assert property (len_go && !reg_wr |=> xfer_done.len)
    else $error("cycle length transfer missed");
  dt_cause_a: assert property (xfer_done.dt |-> $past(dt_go))
    else $error("dead-time moved without permission");
  dt_fire_a: assert property (dt_go && !reg_wr |=> xfer_done.dt)
    else $error("dead-time transfer missed");
  adca_cause_a: assert property (xfer_done.adc_a |-> $past(a_go))
    else $error("timing A moved without permission");
  adca_fire_a: assert property (a_go && !reg_wr |=> xfer_done.adc_a)
    else $error("timing A transfer missed");
  adcb_cause_a: assert property (xfer_done.adc_b |-> $past(b_go))
    else $error("timing B moved without permission");
  adcb_fire_a: assert property (b_go && !reg_wr |=> xfer_done.adc_b)
    else $error("timing B transfer missed");
endmodule // pwm_buffer_mode_select_assertions

`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench for the PWM buffer mode select block
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] SAW = pwm_mode_pkg::SHAPE_SAW;
  localparam logic [2:0] TR3 = pwm_mode_pkg::SHAPE_TRI3;
  localparam logic [2:0] TR4 = pwm_mode_pkg::SHAPE_TRI4;
  localparam logic [7:0] WK [4] = '{8'h84, 8'h7C, 8'h68, 8'h08};
  localparam logic [7:0] SH [4] = '{8'h88, 8'h80, 8'h70, 8'h14};
  localparam logic [2:0] SHP [4] = '{SAW, TR3, TR4, 3'h0};
  logic                       sys_clk = 1'b0;
  logic                       sys_rst = 1'b1;
  logic [7:0]                 reg_addr = 8'h00;
  logic [31:0]                reg_wdata = 32'h00000000;
  logic                       reg_wr = 1'b0;
  logic                       reg_rd = 1'b0;
  logic                       timer_running = 1'b0;
  logic [31:0]                reg_rdata;
  logic [31:0]                lfsr = 32'h000114C4;
  pwm_mode_pkg::counter_evt_t counter_evt = 3'h0;
  pwm_mode_pkg::buf_en_t      common_buffer_enable = 4'h0;
  pwm_mode_pkg::mode_fields_t mode_fields;
  pwm_mode_pkg::xfer_t        xfer_done;
  logic [15:0]                len_w, rise_w, fall_w, a_w, b_w;
  int                         mismatches = 0;
  int                         checks = 0;

  always #4 sys_clk = ~sys_clk;

  pwm_buffer_mode_select #(.DATA_W(16)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_running(timer_running),
    .counter_evt(counter_evt), .common_buffer_enable(common_buffer_enable),
    .mode_fields(mode_fields), .cycle_length(len_w), .deadtime_rise(rise_w),
    .deadtime_fall(fall_w), .adc_start_timing_a(a_w), .adc_start_timing_b(b_w),
    .xfer_done(xfer_done)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic exp_go(input int k, input logic [2:0] s, input logic [1:0] sel,
                                  input logic [2:0] ev, input logic [3:0] en);
    logic saw, tri_m;
    saw = s == SAW;
    tri_m = s == TR3 || s == TR4;
    case (k)
      3: return sel[0] && (saw ? ev[2] : tri_m && ev[0]);
      2: return sel[0] && en[1] && en[0] && (saw ? ev[2] : tri_m && (ev[0] || s == TR4 && ev[1]));
      default: return en[2+k] && (saw ? sel == 2'h1 && ev[2] :
                      tri_m && (sel[0] && ev[1] || sel[1] && ev[0]));
    endcase
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // A gap cycle after each strobe keeps every driver edge single-assigned
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic set_mode(input logic [2:0] s, input logic [1:0] sel);
    wr(8'h00, 32'h00010010 | {7'h00, sel, sel, 1'b0, sel[0], sel[0], 14'h0000, s, 1'b0});
  endtask

  // Shadow and working get opposite values so a missed or stray move shows
  task automatic try(input int k, input logic [2:0] ev, input logic go);
    logic [31:0] v, w, r;
    v = rnd() & 32'h0000FFFF;
    w = ~v & 32'h0000FFFF;
    wr(SH[k], v);
    wr(WK[k], w);
    if (k == 2) begin
      wr(8'h74, v);
      wr(8'h6C, w);
    end
    counter_evt <= ev;
    @(posedge sys_clk);
    counter_evt <= 3'h0;
    #1;
    chk_flag(xfer_done[k], go);
    @(posedge sys_clk);
    rd(WK[k], r);
    chk_val(r, go ? v : w);
    chk_val(32'({len_w, rise_w, a_w, b_w} >> (16 * k)) & 32'h0000FFFF, go ? v : w);
    if (k == 2)
      chk_val({16'h0000, fall_w}, go ? v : w);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, m;
    logic [2:0]  ev;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a < 256; a += 4) begin
      rd(8'(a), r);
      chk_val(r, 32'h00000000);
    end
    wr(8'hF0, rnd());
    rd(8'hF0, r);
    chk_val(r, 32'h00000000);
    $display("test reset done");
    repeat (20) begin
      m = rnd() & ~32'h1E020000;
      wr(8'h00, m);
      rd(8'h00, r);
      chk_val(r, m & pwm_mode_pkg::MODE_WMASK);
    end
    $display("test mode done");
    timer_running <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      for (int sel = 0; sel < 4; sel++) begin
        if ((SHP[i] == SAW || SHP[i] == 3'h0) && sel > 1)
          continue;
        set_mode(SHP[i], 2'(sel));
        for (int k = 0; k < 4; k++) begin
          for (int e = 0; e < 3; e++) begin
            if (SHP[i] == SAW ? e != 2 : (SHP[i] != 3'h0 && e == 2))
              continue;
            ev = 3'h1 << e;
            m = rnd();
            common_buffer_enable <= m[3:0];
            try(k, ev, exp_go(k, SHP[i], 2'(sel), ev, m[3:0]));
          end
        end
      end
    end
    $display("test transfer done");
    timer_running <= 1'b0;
    common_buffer_enable <= 4'hF;
    set_mode(SAW, 2'h1);
    try(3, 3'h4, 1'b0);
    try(1, 3'h4, 1'b0);
    $display("test stopped done");
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    $display("BAD %0t timeout", $time);
    end_sim();
  end
endmodule // tb

bind pwm_buffer_mode_select pwm_buffer_mode_select_assertions #(.DATA_W(DATA_W)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_running(timer_running),
  .counter_evt(counter_evt), .common_buffer_enable(common_buffer_enable),
  .mode_fields(mode_fields), .cycle_length(cycle_length), .deadtime_rise(deadtime_rise),
  .deadtime_fall(deadtime_fall), .adc_start_timing_a(adc_start_timing_a),
  .adc_start_timing_b(adc_start_timing_b), .xfer_done(xfer_done)
);

`default_nettype wire
